// ### rtl/ivre_top.v
// Interrupt vector arbitration and reset entry sequencer
`include "ivre_map.vh"

// Contract
// RULE1 - Sources numbered 0 to 53; handler vector is number plus eight.
// RULE2 - Equal user priority: lower interrupt number wins.
// RULE3 - External inputs one to five sit at numbers 0, 16, 23, 36, 37.
// RULE4 - Timer one at 3, serial receive 9, transmit 10, conversion done 11.
// RULE5 - Reset bypasses arbitration; core initialises and program counter goes to zero.
// RULE6 - Start at address zero, read jump and its target, continue at target.
// RULE7 - Watchdog expiry causes a reset.
// RULE8 - Unwritten working register used as pointer causes a reset.
// RULE9 - Executed unused opcode resets; flushed illegal fetch does not.
// RULE10 - Brown-out dip causes a reset.
// RULE11 - Simultaneous trap conditions cause a lockout reset.
// RULE12 - Trap conflict reset sets bit 15 of reset control register.
// RULE13 - User priority 1 lowest to 7 highest; priority 0 disables source.
// RULE14 - All causes merge into one synchronous reset request with cause recorded.
module ivre_top #(
    parameter NSRC = `IVRE_NUM_SRC,
    parameter NTRAP = 4
) (
    input  wire              clk_sys,
    input  wire              reset,
    input  wire              external_irq_first,
    input  wire              external_irq_second,
    input  wire              external_irq_third,
    input  wire              external_irq_fourth,
    input  wire              external_irq_fifth,
    input  wire              timer_one_irq,
    input  wire              serial_one_receive_irq,
    input  wire              serial_one_transmit_irq,
    input  wire              adc_done_irq,
    input  wire [NSRC-1:0]   periph_irq,
    input  wire [3*NSRC-1:0] src_priority,
    input  wire [3:0]        cpu_level,
    input  wire              watchdog_expired,
    input  wire              uninit_wreg_pointer,
    input  wire              illegal_op_exec,
    input  wire              illegal_op_flushed,
    input  wire              brownout_detect,
    input  wire [NTRAP-1:0]  hard_trap_event,
    input  wire              hard_trap_busy,
    input  wire [15:0]       rc_clear_bits,
    input  wire              fetch_valid,
    input  wire [23:0]       fetch_data,
    output reg               irq_req,
    output reg  [5:0]        irq_number,
    output reg  [6:0]        irq_vector,
    output reg  [2:0]        irq_level,
    output reg               core_reset_req,
    output reg               pc_force_zero,
    output reg               fetch_req,
    output reg  [23:0]       fetch_addr,
    output reg               start_valid,
    output reg  [23:0]       start_pc,
    output wire [15:0]       reset_control_register,
    output wire              trap_reset_flag
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [4:0] ext_sync;
    wire       brownout_sync;

    // Brownout rides the same synchroniser as the external pins
    ivre_sync2 #(.WIDTH(6)) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({brownout_detect, external_irq_fifth, external_irq_fourth,
                    external_irq_third, external_irq_second, external_irq_first}),
        .sync_out ({brownout_sync, ext_sync})
    );

    // ----------------------------------------
    // Source map
    // ----------------------------------------
    // Named inputs OR into the shared vector so either path can raise a source
    reg [NSRC-1:0] src_req;

    always @* begin
        src_req = periph_irq;
        src_req[`IVRE_IRQ_EXT_FIRST]  = periph_irq[`IVRE_IRQ_EXT_FIRST] | ext_sync[0];    // RULE3
        src_req[`IVRE_IRQ_EXT_SECOND] = periph_irq[`IVRE_IRQ_EXT_SECOND] | ext_sync[1];   // RULE3
        src_req[`IVRE_IRQ_EXT_THIRD]  = periph_irq[`IVRE_IRQ_EXT_THIRD] | ext_sync[2];    // RULE3
        src_req[`IVRE_IRQ_EXT_FOURTH] = periph_irq[`IVRE_IRQ_EXT_FOURTH] | ext_sync[3];   // RULE3
        src_req[`IVRE_IRQ_EXT_FIFTH]  = periph_irq[`IVRE_IRQ_EXT_FIFTH] | ext_sync[4];    // RULE3
        src_req[`IVRE_IRQ_TIMER_ONE]  = periph_irq[`IVRE_IRQ_TIMER_ONE] | timer_one_irq;  // RULE4
        src_req[`IVRE_IRQ_SER_RX]     = periph_irq[`IVRE_IRQ_SER_RX] | serial_one_receive_irq;   // RULE4
        src_req[`IVRE_IRQ_SER_TX]     = periph_irq[`IVRE_IRQ_SER_TX] | serial_one_transmit_irq;  // RULE4
        src_req[`IVRE_IRQ_ADC_DONE]   = periph_irq[`IVRE_IRQ_ADC_DONE] | adc_done_irq;    // RULE4
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    // Ascending scan with strict compare keeps the lowest number on a tie
    integer    i;
    reg        win_any;
    reg [5:0]  win_num;
    reg [2:0]  win_prio;
    reg [2:0]  cur_prio;

    always @* begin
        win_any  = 1'b0;
        win_num  = 6'h00;
        win_prio = `IVRE_PRIO_OFF;
        cur_prio = `IVRE_PRIO_OFF;
        for (i = 0; i < NSRC; i = i + 1) begin
            cur_prio = src_priority[3*i +: 3];
            if (src_req[i] && cur_prio != `IVRE_PRIO_OFF && cur_prio > win_prio) begin // RULE13 RULE2
                win_any  = 1'b1;
                win_num  = i[5:0];                                                     // RULE1
                win_prio = cur_prio;
            end
        end
    end

    // ----------------------------------------
    // Reset causes
    // ----------------------------------------
    reg [NTRAP-1:0] trap_bits;
    reg [2:0]       trap_count;
    integer         k;

    always @* begin
        trap_bits  = hard_trap_event;
        trap_count = 3'h0;
        for (k = 0; k < NTRAP; k = k + 1) begin
            trap_count = trap_count + {2'h0, trap_bits[k]};
        end
    end

    // ----------------------------------------
    // Trap conflict
    // ----------------------------------------
    // Conflict: two at once, or a new one while another is still owned
    wire trap_conflict = (trap_count > 3'h1) || (|hard_trap_event && hard_trap_busy);        // RULE11
    wire illegal_hit   = illegal_op_exec && !illegal_op_flushed;                              // RULE9

    // ----------------------------------------
    // Cause merge
    // ----------------------------------------
    reg [15:0] cause_set;

    always @* begin
        cause_set = 16'h0000;
        cause_set[`IVRE_RC_BROWNOUT] = brownout_sync;                                         // RULE10
        cause_set[`IVRE_RC_WATCHDOG] = watchdog_expired;                                      // RULE7
        cause_set[`IVRE_RC_UNINIT_W] = uninit_wreg_pointer;                                   // RULE8
        cause_set[`IVRE_RC_ILLEGAL]  = illegal_hit;                                           // RULE9
        cause_set[`IVRE_RC_TRAP]     = trap_conflict;                                         // RULE12
    end

    wire any_cause = |cause_set;

    // ----------------------------------------
    // Cause register
    // ----------------------------------------
    // Set wins over a clear landing in the same cycle; the block is not reset by its own request
    reg [15:0] rc_q;
    wire [15:0] rc_d = (rc_q & ~rc_clear_bits) | cause_set;                                   // RULE14

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rc_q <= `IVRE_RC_RESET_VAL;
        end else begin
            rc_q <= rc_d;
        end
    end

    assign reset_control_register = rc_q;
    assign trap_reset_flag        = rc_q[`IVRE_RC_TRAP];                                      // RULE12

    // ----------------------------------------
    // Reset entry sequencer
    // ----------------------------------------
    // ZERO forces the counter, OP and TGT fetch the entry words, RUN offers vectors
    // Limitation: the jump opcode itself is not decoded, only its target word is used
    localparam ST_ZERO = 2'h0;
    localparam ST_OP   = 2'h1;
    localparam ST_TGT  = 2'h2;
    localparam ST_RUN  = 2'h3;

    reg [1:0] state_q;
    reg [1:0] state_d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_ZERO: begin
                state_d = ST_OP;                                                              // RULE5
            end
            ST_OP: begin
                if (fetch_valid) begin
                    state_d = ST_TGT;                                                         // RULE6
                end
            end
            ST_TGT: begin
                if (fetch_valid) begin
                    state_d = ST_RUN;                                                         // RULE6
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        if (any_cause) begin
            state_d = ST_ZERO;                                                                // RULE14
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= ST_ZERO;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Reset request outputs
    // ----------------------------------------
    // Request follows every cycle of cause so a held cause keeps the core parked
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            core_reset_req <= 1'b0;
            pc_force_zero  <= 1'b1;
        end else begin
            core_reset_req <= any_cause;                                                      // RULE14
            pc_force_zero  <= (state_d == ST_ZERO);                                           // RULE5
        end
    end

    // ----------------------------------------
    // Entry fetch outputs
    // ----------------------------------------
    // Address comes from the next state so it stands together with the request
    wire fetch_next = (state_d == ST_OP) || (state_d == ST_TGT);

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fetch_req  <= 1'b0;
            fetch_addr <= `IVRE_RESET_ADDR;
        end else begin
            fetch_req  <= fetch_next;
            fetch_addr <= (state_d == ST_TGT) ? `IVRE_TARGET_ADDR : `IVRE_RESET_ADDR;         // RULE6
        end
    end

    // ----------------------------------------
    // Start address outputs
    // ----------------------------------------
    // A cause landing on the answering edge withholds the start pulse
    wire tgt_taken = (state_q == ST_TGT) && fetch_valid;

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            start_valid <= 1'b0;
            start_pc    <= `IVRE_RESET_ADDR;
        end else begin
            start_valid <= tgt_taken && !any_cause;                                           // RULE6
            if (tgt_taken) begin
                start_pc <= fetch_data;                                                       // RULE6
            end
        end
    end

    // ----------------------------------------
    // Vector offer
    // ----------------------------------------
    // No vector is offered until reset entry is complete
    wire       level_ok   = ({1'b0, win_prio} > cpu_level);
    wire [6:0] win_vector = {1'b0, win_num} + `IVRE_VEC_OFFSET;                               // RULE1

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_req    <= 1'b0;
            irq_number <= 6'h00;
            irq_vector <= 7'h00;
            irq_level  <= 3'h0;
        end else begin
            irq_req    <= (state_d == ST_RUN) && win_any && level_ok;                         // RULE5
            irq_number <= win_num;
            irq_vector <= win_vector;                                                         // RULE1
            irq_level  <= win_prio;
        end
    end
endmodule

// ### include/ivre_map.vh
// Constants for the interrupt vector and reset entry block
`ifndef IVRE_MAP_VH
`define IVRE_MAP_VH
// ----------------------------------------
// Interrupt numbering
// ----------------------------------------
`define IVRE_NUM_SRC        54
`define IVRE_VEC_OFFSET     7'h08
`define IVRE_IRQ_EXT_FIRST  0
`define IVRE_IRQ_TIMER_ONE  3
`define IVRE_IRQ_SER_RX     9
`define IVRE_IRQ_SER_TX     10
`define IVRE_IRQ_ADC_DONE   11
`define IVRE_IRQ_EXT_SECOND 16
`define IVRE_IRQ_EXT_THIRD  23
`define IVRE_IRQ_EXT_FOURTH 36
`define IVRE_IRQ_EXT_FIFTH  37
`define IVRE_PRIO_OFF       3'h0
// ----------------------------------------
// Reset entry
// ----------------------------------------
`define IVRE_RESET_ADDR     24'h000000
`define IVRE_TARGET_ADDR    24'h000002
// ----------------------------------------
// Reset control register fields
// ----------------------------------------
`define IVRE_RC_BROWNOUT    0
`define IVRE_RC_WATCHDOG    4
`define IVRE_RC_UNINIT_W    9
`define IVRE_RC_ILLEGAL     14
`define IVRE_RC_TRAP        15
`define IVRE_RC_RESET_VAL   16'h0000
`endif

// ### rtl/ivre_sync2.v
// Two-flop level synchroniser, one per bit
module ivre_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ### dv/ivre_core_model.sv
// Core side model answering the reset-entry program fetches
module ivre_core_model #(
    parameter logic [23:0] TGT = 24'h0001a4
) (
    input  wire        clk_sys,
    input  wire        slow,
    input  wire        fetch_req,
    input  wire [23:0] fetch_addr,
    output logic        fetch_valid,
    output logic [23:0] fetch_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_q;
    logic       go;
    initial begin
        fetch_valid = 1'b0;
        fetch_data = 24'h000000;
        wait_q = 2'h0;
    end
    assign go = fetch_req && !fetch_valid && (!slow || wait_q == 2'h2);
    // Idle data toggles so a stale word can never pass for an answer
    always @(posedge clk_sys) begin
        wait_q <= (fetch_req && !fetch_valid) ? wait_q + 2'h1 : 2'h0;
        fetch_valid <= go;
        fetch_data <= go ? ((fetch_addr == 24'h000000) ? 24'h040000 : TGT) : ~fetch_data;
    end
endmodule

// ### dv/ivre_top_assertions.sv
// Concurrent checks on the vector and reset entry ports
module ivre_top_assertions #(
    parameter NTRAP = 4
) (
    input wire             clk_sys,
    input wire             reset,
    input wire             watchdog_expired,
    input wire             uninit_wreg_pointer,
    input wire             illegal_op_exec,
    input wire             illegal_op_flushed,
    input wire [NTRAP-1:0] hard_trap_event,
    input wire             irq_req,
    input wire [5:0]       irq_number,
    input wire [6:0]       irq_vector,
    input wire             core_reset_req,
    input wire             pc_force_zero,
    input wire             fetch_req,
    input wire             fetch_valid,
    input wire [23:0]      fetch_addr,
    input wire             start_valid,
    input wire [15:0]      reset_control_register,
    input wire             trap_reset_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_vec_slot: assert property (irq_req |-> irq_vector == irq_number + 7'h08 && irq_number < 6'h36)
        else $error("vector slot wrong");
    a_wdog_rst: assert property (watchdog_expired |=> core_reset_req && reset_control_register[4])
        else $error("watchdog reset missing");
    a_uninit_rst: assert property (uninit_wreg_pointer |=> core_reset_req && reset_control_register[9])
        else $error("pointer reset missing");
    a_illegal_rst: assert property (illegal_op_exec && !illegal_op_flushed |=> reset_control_register[14])
        else $error("illegal opcode reset missing");
    a_trap_lock: assert property ($countones(hard_trap_event) > 1 |=> core_reset_req && trap_reset_flag)
        else $error("trap lockout reset missing");
    a_trap_bit: assert property (trap_reset_flag == reset_control_register[15])
        else $error("trap flag differs from bit 15");
    a_reset_zero: assert property (core_reset_req |-> pc_force_zero)
        else $error("program counter not forced");
    a_no_arb: assert property (pc_force_zero |-> !irq_req)
        else $error("request offered during reset");
    a_jump_tgt: assert property (fetch_req && fetch_valid && fetch_addr == 24'h0 |=> fetch_req && fetch_addr == 24'h2)
        else $error("target fetch missing");
    cover property (start_valid);
    cover property (trap_reset_flag);
    cover property (irq_req && irq_number == 6'h25);
endmodule
bind ivre_top ivre_top_assertions #(.NTRAP(NTRAP)) i_ivre_top_assertions (.*);

// ### dv/ivre_top_test.sv
// Self-checking bench for the vector and reset entry block
module ivre_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] TGT = 24'h0001a4;
    localparam int NUMS [9] = '{0, 16, 23, 36, 37, 3, 9, 10, 11};
    logic clk_sys, reset, slow, fetch_valid, fetch_req, start_valid, irq_req;
    logic external_irq_first, external_irq_second, external_irq_third, external_irq_fourth, external_irq_fifth;
    logic timer_one_irq, serial_one_receive_irq, serial_one_transmit_irq, adc_done_irq;
    logic watchdog_expired, uninit_wreg_pointer, illegal_op_exec, illegal_op_flushed, brownout_detect;
    logic hard_trap_busy, core_reset_req, pc_force_zero, trap_reset_flag;
    logic [53:0] periph_irq;
    logic [161:0] src_priority;
    logic [3:0] cpu_level, hard_trap_event;
    logic [15:0] rc_clear_bits, reset_control_register;
    logic [23:0] fetch_data, fetch_addr, start_pc;
    logic [5:0] irq_number;
    logic [6:0] irq_vector;
    logic [2:0] irq_level;
    int n_fail = 0, total_checks = 0, cyc = 0;
    ivre_top i_ivre_top (.*);
    ivre_core_model #(.TGT(TGT)) i_ivre_core_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Whole run needs well under two thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic set_named(input logic [8:0] v);
        {external_irq_first, external_irq_second, external_irq_third, external_irq_fourth, external_irq_fifth,
         timer_one_irq, serial_one_receive_irq, serial_one_transmit_irq, adc_done_irq} <= v;
    endtask
    task automatic clr_causes();
        {watchdog_expired, uninit_wreg_pointer, illegal_op_exec, illegal_op_flushed, brownout_detect} <= 5'h0;
        {hard_trap_event, hard_trap_busy} <= 5'h0;
    endtask
    task automatic wait_start();
        for (int i = 0; i < 30 && start_valid !== 1'b1; i++) @(negedge clk_sys);
        chk("start_valid", 1, start_valid);
        chk("start_pc", TGT, start_pc);
    endtask
    task automatic arb(input logic [53:0] m, input logic r, input logic [5:0] n);
        @(posedge clk_sys);
        periph_irq <= m;
        repeat (2) @(negedge clk_sys);
        chk("irq_req", r, irq_req);
        if (r) chk("irq_number", n, irq_number);
        if (r) chk("irq_vector", n + 7'h08, irq_vector);
    endtask
    task automatic t_boot(input logic s);
        @(posedge clk_sys);
        reset <= 1'b1;
        slow <= s;
        periph_irq <= 54'h1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        chk("pc_force_zero", 1, pc_force_zero);
        chk("irq_req", 0, irq_req);
        repeat (2) @(negedge clk_sys);
        chk("fetch_req", 1, fetch_req);
        chk("fetch_addr", 0, fetch_addr);
        wait_start();
        chk("pc_force_zero", 0, pc_force_zero);
    endtask
    task automatic t_arb();
        arb(54'h1080, 1, 7);
        arb({1'b1, 7'h0, 1'b1, 45'h0}, 1, 45);
        @(posedge clk_sys);
        src_priority[122:120] <= 3'h5;
        src_priority[8:6] <= 3'h0;
        arb(54'h1 << 40 | 54'h1, 1, 40);
        chk("irq_level", 5, irq_level);
        @(posedge clk_sys);
        cpu_level <= 4'h5;
        arb(54'h1 << 40, 0, 0);
        @(posedge clk_sys);
        cpu_level <= 4'h4;
        arb(54'h1 << 40, 1, 40);
        @(posedge clk_sys);
        cpu_level <= 4'h0;
        arb(54'h4, 0, 0);
        arb(54'h4 | 54'h1 << 50, 1, 50);
        @(posedge clk_sys);
        src_priority <= {54{3'h1}};
    endtask
    task automatic t_named();
        @(posedge clk_sys);
        periph_irq <= 54'h0;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            set_named(9'h100 >> i);
            repeat (5) @(negedge clk_sys);
            chk("named irq", NUMS[i], irq_number);
        end
        @(posedge clk_sys);
        set_named(9'h0);
    endtask
    task automatic t_cause(input int c, input int b);
        @(posedge clk_sys);
        case (c)
            0: watchdog_expired <= 1'b1;
            1: uninit_wreg_pointer <= 1'b1;
            2: illegal_op_exec <= 1'b1;
            3: {illegal_op_exec, illegal_op_flushed} <= 2'h3;
            4: brownout_detect <= 1'b1;
            5: hard_trap_event <= 4'h3;
            6: {hard_trap_event, hard_trap_busy} <= 5'h03;
            default: hard_trap_event <= 4'h4;
        endcase
        @(posedge clk_sys);
        clr_causes();
        for (int i = 0; i < 8 && core_reset_req !== 1'b1; i++) @(negedge clk_sys);
        chk("core_reset_req", b >= 0, core_reset_req);
        chk("rc", b >= 0 ? 16'h1 << b : 16'h0, reset_control_register);
        chk("trap_reset_flag", b == 15, trap_reset_flag);
        if (b >= 0) wait_start();
        @(posedge clk_sys);
        rc_clear_bits <= 16'hffff;
        @(posedge clk_sys);
        rc_clear_bits <= 16'h0;
        @(negedge clk_sys);
        chk("rc cleared", 0, reset_control_register);
    endtask
    initial begin
        reset = 1'b1;
        slow = 1'b0;
        periph_irq = 54'h0;
        src_priority = {54{3'h1}};
        cpu_level = 4'h0;
        rc_clear_bits = 16'h0;
        set_named(9'h0);
        clr_causes();
        t_boot(1'b0);
        for (int i = 0; i < 54; i++) arb(54'h1 << i, 1, 6'(i));
        t_arb();
        t_named();
        t_cause(0, 4);
        t_cause(1, 9);
        t_cause(2, 14);
        t_cause(3, -1);
        t_cause(4, 0);
        t_cause(5, 15);
        t_cause(6, 15);
        t_cause(7, -1);
        t_boot(1'b1);
        finish_test();
    end
endmodule
